// [design/rpsel_consts.svh]
`ifndef RPSEL_CONSTS_SVH
`define RPSEL_CONSTS_SVH

// Register indices (word addresses on the register port)
`define RPSEL_IDX_IRQ1_TRIG1 5'h00
`define RPSEL_IDX_IRQ2_IRQ3 5'h01
`define RPSEL_IDX_IRQ4_TRIG2 5'h02
`define RPSEL_IDX_TMR2_TMR3 5'h03
`define RPSEL_IDX_TMR4_TMR5 5'h04
`define RPSEL_IDX_CAP1_CAP2 5'h07
`define RPSEL_IDX_CAP3 5'h08
`define RPSEL_IDX_OCFAULT 5'h0B
`define RPSEL_IDX_CCP_CLK 5'h0C
`define RPSEL_IDX_UART3_RX 5'h11
`define RPSEL_IDX_UART1 5'h12
`define RPSEL_IDX_UART2 5'h13
`define RPSEL_IDX_SPI1 5'h14
`define RPSEL_IDX_OSC_CTRL 5'h1F

// Field layout
`define RPSEL_HI_LSB 8
`define RPSEL_LO_LSB 0
`define RPSEL_LOCK_BIT 6

// Reset values
`define RPSEL_SEL_RST 6'h3F
`define RPSEL_LOCK_RST 1'h0

// Unlock keys written to the low byte of the oscillator control register
`define RPSEL_KEY1 8'h46
`define RPSEL_KEY2 8'h57

// Pin space: codes 0..31 are I/O pins, 32..43 input-only pins
`define RPSEL_NUM_PINS 44
`define RPSEL_NUM_FIELDS 24

`endif

// [design/rpsel_pkg.sv]
`default_nettype none
package rpsel_pkg;

   typedef struct packed {
      logic [4:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } rpsel_bus_t;

   typedef struct packed {
      logic [4:0] index;
      logic hi;
   } rpsel_field_t;

   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_KEY1,
      SEQ_ARMED
   } rpsel_seq_t;

endpackage
`default_nettype wire

// [design/rpsel_top.sv]
// How it works
// - 36 selector registers; 13 input here
// - Selector writes ignored while lock is set
// - Two 6-bit codes, unused bits read zero
// - Codes route pins to interrupts one-four
// - Codes route pins to compare triggers, faults
// - Codes route pins to timer clocks 2-5
// - Codes route pins to captures one-three
// - Codes route pins to CCP clocks A, B
// - Codes route pins to UART receive, CTS
// - Capture-three register has low field only
// - UART3 receive register has high field only
// - Reset: input codes all ones, tie low
// - Lock changes only after 46h, 57h keys
// - Unimplemented pin code drives input low
// - Codes route pins to SPI1 clock, data
`include "rpsel_consts.svh"
`default_nettype none

module rpsel_top
   import rpsel_pkg::*;
#(
   // One bit per pin code; a cleared bit marks a pin not bonded out
   parameter logic [43:0] PIN_IMPL = 44'hFFF_FFFF_FFFF
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire rpsel_bus_t bus_req,
   output logic [15:0] rdata,
   // Remappable pins in, routed peripheral inputs out
   input wire logic [43:0] pin_in,
   output logic [23:0] periph_in,
   // Lock state
   output logic pin_map_lock
);

   // Field table; one entry per routed peripheral input
   localparam rpsel_field_t FMAP [`RPSEL_NUM_FIELDS] = '{
      '{`RPSEL_IDX_IRQ1_TRIG1, 1'b1}, // ext_irq1
      '{`RPSEL_IDX_IRQ1_TRIG1, 1'b0}, // oc_trigger1
      '{`RPSEL_IDX_IRQ2_IRQ3, 1'b1}, // ext_irq3
      '{`RPSEL_IDX_IRQ2_IRQ3, 1'b0}, // ext_irq2
      '{`RPSEL_IDX_IRQ4_TRIG2, 1'b1}, // oc_trigger2
      '{`RPSEL_IDX_IRQ4_TRIG2, 1'b0}, // ext_irq4
      '{`RPSEL_IDX_TMR2_TMR3, 1'b1}, // timer3 clk
      '{`RPSEL_IDX_TMR2_TMR3, 1'b0}, // timer2 clk
      '{`RPSEL_IDX_TMR4_TMR5, 1'b1}, // timer5 clk
      '{`RPSEL_IDX_TMR4_TMR5, 1'b0}, // timer4 clk
      '{`RPSEL_IDX_CAP1_CAP2, 1'b1}, // capture2
      '{`RPSEL_IDX_CAP1_CAP2, 1'b0}, // capture1
      '{`RPSEL_IDX_CAP3, 1'b0}, // capture3, low only
      '{`RPSEL_IDX_OCFAULT, 1'b1}, // oc_fault_b
      '{`RPSEL_IDX_OCFAULT, 1'b0}, // oc_fault_a
      '{`RPSEL_IDX_CCP_CLK, 1'b1}, // ccp_clk_b
      '{`RPSEL_IDX_CCP_CLK, 1'b0}, // ccp_clk_a
      '{`RPSEL_IDX_UART3_RX, 1'b1}, // uart3 rx, high only
      '{`RPSEL_IDX_UART1, 1'b1}, // uart1 cts
      '{`RPSEL_IDX_UART1, 1'b0}, // uart1 rx
      '{`RPSEL_IDX_UART2, 1'b1}, // uart2 cts
      '{`RPSEL_IDX_UART2, 1'b0}, // uart2 rx
      '{`RPSEL_IDX_SPI1, 1'b1}, // spi1 clk
      '{`RPSEL_IDX_SPI1, 1'b0} // spi1 data
   };

   // Places a code in its half of a register word; other bits stay zero
   function automatic logic [15:0] place(input logic [5:0] code,
                                         input logic hi);
      logic [15:0] word;
      word = 16'h0000;
      if (hi)
      begin
         word[`RPSEL_HI_LSB +: 6] = code;
      end
      else
      begin
         word[`RPSEL_LO_LSB +: 6] = code;
      end
      return word;
   endfunction

   logic [23:0][5:0] sel;
   logic [23:0][5:0] next_sel;
   logic [23:0] next_periph_in;
   logic [24:0][15:0] rd_acc;
   logic [15:0] next_rdata;
   logic next_lock;
   rpsel_seq_t seq_state;
   rpsel_seq_t next_seq_state;

   // Codes 44..63 index the zero padding, so they route nothing
   wire [63:0] impl64 = {20'h00000, PIN_IMPL};
   wire [63:0] pin64 = {20'h00000, pin_in};
   wire osc_hit = bus_req.addr == `RPSEL_IDX_OSC_CTRL;
   wire osc_wr = bus_req.wr && osc_hit;
   wire key1 = bus_req.wdata[7:0] == `RPSEL_KEY1;
   wire key2 = bus_req.wdata[7:0] == `RPSEL_KEY2;
   wire sel_wr_ok = bus_req.wr && !pin_map_lock;
   // Only the lock bit of the oscillator control register lives here
   wire [15:0] osc_word = 16'(pin_map_lock) << `RPSEL_LOCK_BIT;

   assign rd_acc[0] = 16'h0000;

   generate
      for (genvar k = 0; k < `RPSEL_NUM_FIELDS; k++)
      begin : g_fld
         wire hit = bus_req.addr == FMAP[k].index;
         wire [5:0] wfield = FMAP[k].hi ?
            bus_req.wdata[`RPSEL_HI_LSB +: 6] :
            bus_req.wdata[`RPSEL_LO_LSB +: 6];
         // Both halves share one strobe, so they change together
         assign next_sel[k] = (sel_wr_ok && hit) ?
            wfield : sel[k];
         // Unimplemented or out-of-range code leaves the input low
         assign next_periph_in[k] =
            impl64[sel[k]] & pin64[sel[k]];
         assign rd_acc[k + 1] = rd_acc[k] |
            (hit ? place(sel[k], FMAP[k].hi) : 16'h0000);
      end
   endgenerate

   // Unmapped addresses read as zero; data stands for one cycle only
   assign next_rdata = !bus_req.rd ? 16'h0000 :
      (rd_acc[`RPSEL_NUM_FIELDS] | (osc_hit ? osc_word : 16'h0000));

   // Unlock sequence: key1, key2, then the write that loads the lock bit
   always_comb
   begin
      next_seq_state = seq_state;
      next_lock = pin_map_lock;
      if (osc_wr)
      begin
         unique case (seq_state)
            SEQ_IDLE:
            begin
               next_seq_state = key1 ? SEQ_KEY1 : SEQ_IDLE;
            end
            SEQ_KEY1:
            begin
               next_seq_state = key2 ? SEQ_ARMED :
                  (key1 ? SEQ_KEY1 : SEQ_IDLE);
            end
            SEQ_ARMED:
            begin
               next_lock = bus_req.wdata[`RPSEL_LOCK_BIT];
               next_seq_state = SEQ_IDLE;
            end
            default:
            begin
               next_seq_state = SEQ_IDLE;
            end
         endcase
      end
      else if (bus_req.wr)
      begin
         // Any other write breaks the timing-critical sequence
         next_seq_state = SEQ_IDLE;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sel <= {`RPSEL_NUM_FIELDS{`RPSEL_SEL_RST}};
         periph_in <= 24'h000000;
         rdata <= 16'h0000;
         pin_map_lock <= `RPSEL_LOCK_RST;
         seq_state <= SEQ_IDLE;
      end
      else
      begin
         sel <= next_sel;
         periph_in <= next_periph_in;
         rdata <= next_rdata;
         pin_map_lock <= next_lock;
         seq_state <= next_seq_state;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   lock_hold_a: assert property (
      pin_map_lock |=> $stable(sel))
      else $error("selector changed while locked");

   unused_zero_a: assert property (
      bus_req.rd && !osc_hit |=> rdata[15:14] == 2'h0 &&
         rdata[7:6] == 2'h0)
      else $error("unimplemented selector bits read nonzero");

   cap3_high_a: assert property (
      bus_req.rd && bus_req.addr == `RPSEL_IDX_CAP3
         |=> rdata[15:6] == 10'h000)
      else $error("capture3 upper bits read nonzero");

   cap3_write_a: assert property (
      sel_wr_ok && bus_req.addr == `RPSEL_IDX_CAP3
         |=> sel[12] == $past(bus_req.wdata[5:0]))
      else $error("capture three code not written");

   uart3_low_a: assert property (
      bus_req.rd && bus_req.addr == `RPSEL_IDX_UART3_RX
         |=> rdata[7:0] == 8'h00 && rdata[13:8] == $past(sel[17]))
      else $error("uart3 register readback wrong");

   uart3_write_a: assert property (
      sel_wr_ok && bus_req.addr == `RPSEL_IDX_UART3_RX
         |=> sel[17] == $past(bus_req.wdata[13:8]))
      else $error("uart three code not written");

   reset_value_a: assert property (
      $past(rst) |-> sel == {`RPSEL_NUM_FIELDS{`RPSEL_SEL_RST}} &&
         periph_in == 24'h000000 && rdata == 16'h0000 &&
         !pin_map_lock)
      else $error("reset state wrong");

   bad_code_a: assert property (
      sel[0] >= 6'(`RPSEL_NUM_PINS) |=> !periph_in[0])
      else $error("invalid code drove a peripheral input");

   bad_pin_a: assert property (
      sel[1] < 6'(`RPSEL_NUM_PINS) && !impl64[sel[1]]
         |=> !periph_in[1])
      else $error("absent pin drove a peripheral input");

   route_irq1_a: assert property (
      sel[0] < 6'(`RPSEL_NUM_PINS) && PIN_IMPL[sel[0]]
         |=> periph_in[0] == $past(pin_in[sel[0]]))
      else $error("interrupt one not routed from chosen pin");

   route_fault_a: assert property (
      impl64[sel[14]]
         |=> periph_in[14] == $past(pin_in[sel[14]]))
      else $error("fault A input not routed from chosen pin");

   route_timer2_a: assert property (
      impl64[sel[7]]
         |=> periph_in[7] == $past(pin_in[sel[7]]))
      else $error("timer two clock not routed from chosen pin");

   route_capture_a: assert property (
      impl64[sel[12]]
         |=> periph_in[12] == $past(pin_in[sel[12]]))
      else $error("capture three not routed from chosen pin");

   route_ccp_a: assert property (
      impl64[sel[16]]
         |=> periph_in[16] == $past(pin_in[sel[16]]))
      else $error("ccp clock A not routed from chosen pin");

   route_uart1_a: assert property (
      sel[19] < 6'(`RPSEL_NUM_PINS) && PIN_IMPL[sel[19]]
         |=> periph_in[19] == $past(pin_in[sel[19]]))
      else $error("uart1 receive not routed from chosen pin");

   route_spi1_a: assert property (
      impl64[sel[22]]
         |=> periph_in[22] == $past(pin_in[sel[22]]))
      else $error("spi1 clock not routed from chosen pin");

   both_fields_a: assert property (
      bus_req.wr && !pin_map_lock &&
         bus_req.addr == `RPSEL_IDX_SPI1
      |=> sel[22] == $past(bus_req.wdata[13:8]) &&
         sel[23] == $past(bus_req.wdata[5:0]))
      else $error("two-field write did not update both fields");

   lock_seq_a: assert property (
      $changed(pin_map_lock) |-> $past(seq_state) == SEQ_ARMED &&
         $past(osc_wr))
      else $error("lock changed without unlock sequence");

   lock_read_a: assert property (
      bus_req.rd && osc_hit
         |=> rdata == 16'($past(pin_map_lock)) << `RPSEL_LOCK_BIT)
      else $error("lock bit read back in wrong place");

   seq_break_a: assert property (
      bus_req.wr && !osc_wr |=> seq_state == SEQ_IDLE)
      else $error("unlock sequence survived another write");

   unlock_cov: cover property (
      osc_wr && key1 ##1 osc_wr && key2 ##1
         osc_wr && !bus_req.wdata[`RPSEL_LOCK_BIT]);

   locked_write_cov: cover property (
      pin_map_lock && bus_req.wr && !osc_hit);

   routed_cov: cover property (
      sel[19] < 6'(`RPSEL_NUM_PINS) ##1 periph_in[19]);

   invalid_cov: cover property (
      sel[0] >= 6'(`RPSEL_NUM_PINS) && sel[0] != `RPSEL_SEL_RST);

   bad_pin_cov: cover property (
      sel[1] < 6'(`RPSEL_NUM_PINS) && !impl64[sel[1]]);

endmodule
`default_nettype wire

// [bench/rpsel_top_test.sv]
`default_nettype none
module rpsel_top_test;
   import rpsel_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0;
   logic rst = 1'b1;
   rpsel_bus_t bus_req = '0;
   logic [15:0] rdata;
   logic [43:0] pin_in = '0;
   logic [23:0] periph_in;
   logic pin_map_lock;
   int err_count = 0;
   int total_checks = 0;
   int cyc = 0;
   int idx [13] = '{0, 1, 2, 3, 4, 7, 8, 11, 12, 17, 18, 19, 20};
   // First routed output of each register: high field, then low field
   int base [13] = '{0, 2, 4, 6, 8, 10, 12, 13, 15, 17, 18, 20, 22};

   always #5 clk = ~clk;

   // Pin 30 left out so an absent pin can be selected
   rpsel_top #(.PIN_IMPL(44'hFFF_BFFF_FFFF)) i_rpsel_top (
      .clk(clk),
      .rst(rst),
      .bus_req(bus_req),
      .rdata(rdata),
      .pin_in(pin_in),
      .periph_in(periph_in),
      .pin_map_lock(pin_map_lock)
   );

   function automatic logic [15:0] mask(int j);
      return (j == 6) ? 16'h003F : (j == 9) ? 16'h3F00 : 16'h3F3F;
   endfunction

   // Capture three has its low field only, so it carries its own code
   function automatic logic [5:0] lo(int j);
      return 6'((j == 6) ? base[j] : base[j] + 1);
   endfunction

   task automatic chk(input string what, input logic [23:0] exp, got);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Strobe stays up until the next call, so writes can run back to back
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      bus_req <= {a, d, 2'b10};
      @(posedge clk);
   endtask

   task automatic idle;
      bus_req <= '0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [4:0] a, input logic [15:0] exp);
      bus_req <= {a, 16'h0000, 2'b01};
      @(posedge clk);
      bus_req <= '0;
      @(negedge clk);
      chk("rdata", {8'h00, exp}, {8'h00, rdata});
      @(posedge clk);
   endtask

   task automatic unlock(input logic [15:0] v);
      wr(5'h1F, 16'h0046);
      wr(5'h1F, 16'h0057);
      wr(5'h1F, v);
      idle();
   endtask

   task automatic settle;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask

   task results;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Runaway guard: the sequence needs under two hundred cycles
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         err_count++;
         results();
      end
   end

   initial
   begin
      repeat (12) @(posedge clk);
      chk("periph_in", 24'h0, periph_in);
      chk("lock", 24'h0, {23'h0, pin_map_lock});
      rst <= 1'b0;
      @(posedge clk);
      for (int j = 0; j < 13; j++)
         rd(5'(idx[j]), mask(j));
      rd(5'h05, 16'h0000);
      rd(5'h1F, 16'h0000);
      // Unused bits set on purpose; field j routes to output = pin code
      for (int j = 0; j < 13; j++)
         wr(5'(idx[j]), {2'b11, 6'(base[j]), 2'b11, lo(j)});
      for (int j = 0; j < 13; j++)
         rd(5'(idx[j]), {2'b00, 6'(base[j]), 2'b00, lo(j)}
            & mask(j));
      for (int k = 0; k < 24; k++)
      begin
         pin_in <= 44'h1 << k;
         settle();
         chk("irq trig fault", (24'h1 << k) & 24'h00603F,
             periph_in & 24'h00603F);
         chk("timer capture", (24'h1 << k) & 24'h001FC0,
             periph_in & 24'h001FC0);
         chk("ccp uart", (24'h1 << k) & 24'h3F8000,
             periph_in & 24'h3F8000);
         chk("spi1", (24'h1 << k) & 24'hC00000,
             periph_in & 24'hC00000);
         @(posedge clk);
      end
      pin_in <= '1;
      wr(5'h00, 16'h2C1E);
      idle();
      settle();
      chk("periph_in", 24'hFFFFFC, periph_in);
      @(posedge clk);
      unlock(16'h0040);
      chk("lock", 24'h1, {23'h0, pin_map_lock});
      rd(5'h1F, 16'h0040);
      wr(5'h00, 16'h0102);
      rd(5'h00, 16'h2C1E);
      wr(5'h1F, 16'h0046);
      wr(5'h01, 16'h0000);
      wr(5'h1F, 16'h0057);
      wr(5'h1F, 16'h0000);
      idle();
      chk("lock", 24'h1, {23'h0, pin_map_lock});
      unlock(16'h0000);
      chk("lock", 24'h0, {23'h0, pin_map_lock});
      wr(5'h00, 16'h0102);
      rd(5'h00, 16'h0102);
      // Reset in mid-run must drop the lock and restore the codes of register 0
      unlock(16'h0040);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("lock", 24'h0, {23'h0, pin_map_lock});
      rd(5'h00, 16'h3F3F);
      results();
   end
endmodule
`default_nettype wire
